// >>> design/ipl_pkg.sv
// Package: offsets, field layout, masks and codes of the priority bank
package ipl_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int REG_W   = 16;
  localparam int FIELD_W = 2;
  localparam int NUM_REG = 4;
  localparam int NUM_SRC = 20;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_THREE = 6'h03;
  localparam logic [5:0] IDX_FOUR  = 6'h04;
  localparam logic [5:0] IDX_FIVE  = 6'h05;
  localparam logic [5:0] IDX_SIX   = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_THREE = {IDX_THREE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FOUR  = {IDX_FOUR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FIVE  = {IDX_FIVE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SIX   = {IDX_SIX, 2'b00};

  // Slot in the internal array for each register
  localparam int SLOT_THREE = 0;
  localparam int SLOT_FOUR  = 1;
  localparam int SLOT_FIVE  = 2;
  localparam int SLOT_SIX   = 3;

  // ---------------------------------------------------------------
  // Reset value and writable-bit masks (reserved bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MASK_THREE = 16'hC03F;
  localparam logic [REG_W-1:0] MASK_FOUR  = 16'hFFFF;
  localparam logic [REG_W-1:0] MASK_FIVE  = 16'hFF00;
  localparam logic [REG_W-1:0] MASK_SIX   = 16'h0FC3;

  // ---------------------------------------------------------------
  // Field encoding
  // ---------------------------------------------------------------
  localparam logic [FIELD_W-1:0] LEVEL_OFF = 2'h0;
  localparam logic [FIELD_W-1:0] LEVEL_STEP = 2'h1;

  // ---------------------------------------------------------------
  // Source table: register slot and field lsb per source index
  //  0 twowire_error_level        10 twowire_receive_level
  //  1 serial0_rx_full_level      11 twowire_general_call_level
  //  2 serial0_rx_error_level     12 interval_timer1_level
  //  3 serial0_tx_idle_level      13 interval_timer0_level
  //  4 gp_timer_ch3_level         14 comparator_b_level
  //  5 gp_timer_ch2_level         15 comparator_a_level
  //  6 gp_timer_ch1_level         16 modulator_fault_level
  //  7 gp_timer_ch0_level         17 modulator_reload_level
  //  8 twowire_status_level       18 converter_zero_cross_level
  //  9 twowire_transmit_level     19 interval_timer2_level
  // ---------------------------------------------------------------
  localparam int SRC_SLOT [NUM_SRC] = '{
    0, 0, 0, 0,
    1, 1, 1, 1, 1, 1, 1, 1,
    2, 2, 2, 2,
    3, 3, 3, 3
  };
  localparam int SRC_LSB [NUM_SRC] = '{
    14, 4, 2, 0,
    14, 12, 10, 8, 6, 4, 2, 0,
    14, 12, 10, 8,
    10, 8, 6, 0
  };

  // ---------------------------------------------------------------
  // AXI response codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> design/ipl_prio_regs.sv
// Interrupt priority level register bank with AXI4-Lite slave
// Notes on behaviour
// - Field 00 off; 01,10,11 are levels 0-2
// - Reset leaves every field disabled
// - Third register 15:14 twowire error level
// - Third register 5:4 serial0 receiver full
// - Third register 3:2 serial0 receiver error
// - Third register 1:0 serial0 transmitter idle
// - Fourth register 15:14 timer ch3, 13:12 ch2
// - Fourth register 11:10 timer ch1, 9:8 ch0
// - Fourth register 7:6 twowire status level
// - Fourth register 5:4 twowire transmit level
// - Fourth register 3:2 twowire receive level
// - Fourth register 1:0 twowire general call
// - Fifth register 15:14 interval timer 1
// - Fifth register 13:12 interval timer 0
// - Fifth register 11:10 comparator B level
// - Fifth register 9:8 comparator A level
// - Sixth register 11:10 modulator fault level
// - Sixth register 9:8 modulator reload level
// - Sixth register 7:6 converter zero crossing
// - Sixth register 1:0 interval timer 2
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module ipl_prio_regs
  import ipl_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [DATA_W-1:0]      s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]    s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [NUM_SRC-1:0]          source_enable,
  output logic [FIELD_W*NUM_SRC-1:0]  source_level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [REG_W-1:0]          prio_r [NUM_REG];
  logic                      awready_r;
  logic                      wready_r;
  logic                      aw_held_r;
  logic                      w_held_r;
  logic [ADDR_W-1:0]         aw_addr_r;
  logic [DATA_W-1:0]         w_data_r;
  logic [DATA_W/8-1:0]       w_strb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      arready_r;
  logic                      rvalid_r;
  logic [1:0]                rresp_r;
  logic [DATA_W-1:0]         rdata_r;
  logic [NUM_SRC-1:0]        source_enable_r;
  logic [FIELD_W*NUM_SRC-1:0] source_level_r;

  logic                      do_write;
  logic                      wr_hit;
  int                        wr_slot;
  logic [REG_W-1:0]          wr_mask;
  logic [REG_W-1:0]          lane_mask;
  logic                      rd_hit;
  logic [REG_W-1:0]          rd_value;

  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_hit  = 1'b1;
    wr_slot = SLOT_THREE;
    wr_mask = MASK_THREE;
    if (aw_addr_r == ADDR_THREE) begin
      wr_slot = SLOT_THREE;
      wr_mask = MASK_THREE;
    end else if (aw_addr_r == ADDR_FOUR) begin
      wr_slot = SLOT_FOUR;
      wr_mask = MASK_FOUR;
    end else if (aw_addr_r == ADDR_FIVE) begin
      wr_slot = SLOT_FIVE;
      wr_mask = MASK_FIVE;
    end else if (aw_addr_r == ADDR_SIX) begin
      wr_slot = SLOT_SIX;
      wr_mask = MASK_SIX;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Reserved bits read as zero whatever was written to them
  always_comb begin
    rd_hit   = 1'b1;
    rd_value = PRIO_RESET;
    if (s_axi_araddr == ADDR_THREE) begin
      rd_value = prio_r[SLOT_THREE] & MASK_THREE;
    end else if (s_axi_araddr == ADDR_FOUR) begin
      rd_value = prio_r[SLOT_FOUR] & MASK_FOUR;
    end else if (s_axi_araddr == ADDR_FIVE) begin
      rd_value = prio_r[SLOT_FIVE] & MASK_FIVE;
    end else if (s_axi_araddr == ADDR_SIX) begin
      rd_value = prio_r[SLOT_SIX] & MASK_SIX;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Write channels: address and data captured in either order
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end else if (!aw_held_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Priority registers
  // ---------------------------------------------------------------
  // Lanes above bit 15 have no storage; strobes 3:2 are ignored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REG; i++) begin
        prio_r[i] <= PRIO_RESET;
      end
    end else if (do_write && wr_hit) begin
      prio_r[wr_slot] <= ((prio_r[wr_slot] & ~lane_mask)
                        | (w_data_r[REG_W-1:0] & lane_mask))
                        & wr_mask;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b0;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (s_axi_arvalid && arready_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= {{(DATA_W-REG_W){1'b0}}, rd_value};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Per-source decode toward the arbiter
  // ---------------------------------------------------------------
  // Registered so arbitration never sees a half-written register;
  // costs one cycle after the field changes
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    logic [FIELD_W-1:0] field;
    assign field = prio_r[SRC_SLOT[s]][SRC_LSB[s] +: FIELD_W];
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        source_enable_r[s] <= 1'b0;
        source_level_r[s*FIELD_W +: FIELD_W] <= LEVEL_OFF;
      end else begin
        source_enable_r[s] <= (field != LEVEL_OFF);
        if (field != LEVEL_OFF) begin
          source_level_r[s*FIELD_W +: FIELD_W] <=
            field - LEVEL_STEP;
        end else begin
          source_level_r[s*FIELD_W +: FIELD_W] <= LEVEL_OFF;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign source_enable = source_enable_r;
  assign source_level  = source_level_r;

endmodule

// >>> testbench/ipl_checker.sv
// Bus-answer and decode properties watched at the priority bank's ports
`timescale 1ns/1ps

module ipl_checker
  import ipl_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [ADDR_W-1:0]  s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [DATA_W-1:0]  s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [NUM_SRC-1:0] source_enable,
  input wire logic [2*NUM_SRC-1:0] source_level
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  logic [ADDR_W-1:0] ar_r;
  logic [REG_W-1:0]  rmask;
  logic              lvl_ok;

  // Address of the read in flight, so the answer can be judged
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ar_r <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_r <= s_axi_araddr;
    end
  end
  assign rmask = (ar_r == ADDR_THREE) ? MASK_THREE :
                 (ar_r == ADDR_FOUR)  ? MASK_FOUR  :
                 (ar_r == ADDR_FIVE)  ? MASK_FIVE  :
                 (ar_r == ADDR_SIX)   ? MASK_SIX   : 16'h0000;
  always_comb begin
    lvl_ok = 1'b1;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (source_level[2*s +: 2] == 2'h3) lvl_ok = 1'b0;
      if (!source_enable[s] && source_level[2*s +: 2] != 2'h0) lvl_ok = 1'b0;
    end
  end

  lvl_code_a: assert property (
    lvl_ok) else $error("level code outside decode");
  rst_off_a: assert property (
    $rose(arst_n) |-> source_enable == '0) else $error("source on at reset");
  rsv_zero_a: assert property (
    s_axi_rvalid |-> (s_axi_rdata[15:0] & ~rmask) == 16'h0000)
    else $error("reserved bit read as one");
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  rd_code_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rresp ==
    ((rmask == 16'h0000) ? RESP_SLVERR : RESP_OKAY))
    else $error("read answer wrong");
  src_wr_a: assert property (
    $changed(source_enable) || $changed(source_level) |-> $past(s_axi_bvalid))
    else $error("source changed without write");
endmodule

bind ipl_prio_regs ipl_checker ipl_checker_i (.*);

// >>> testbench/ipl_host_model.sv
// Register bus master standing in for the processor software
`timescale 1ns/1ps

module ipl_host_model
  import ipl_pkg::*;
(
  input  wire logic              sys_clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [DATA_W-1:0]      s_axi_wdata,
  output logic [DATA_W/8-1:0]    s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end

  // Released addresses and write data show their inverse so stale values never look valid; write strobes are left as driven
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input int dly,
                    output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (dly == 0);
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (n >= dly) s_axi_bready <= 1'b1;
    end while (!(s_axi_bready && s_axi_bvalid));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input int dly,
                    output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (dly == 0);
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (n >= dly) s_axi_rready <= 1'b1;
    end while (!(s_axi_rready && s_axi_rvalid));
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the interrupt priority register bank
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch %s exp %0h got %0h", nm, (exp), (got)); \
    end \
  end

module tb
  import ipl_pkg::*;
;
  logic sys_clk, arst_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [NUM_SRC-1:0] source_enable;
  logic [2*NUM_SRC-1:0] source_level;
  logic [15:0] mreg [NUM_REG];
  logic [31:0] rng;
  int num_errors, compares;
  localparam logic [15:0] MSK [NUM_REG] =
    '{MASK_THREE, MASK_FOUR, MASK_FIVE, MASK_SIX};
  // Last entry is an unmapped word just past the bank
  localparam logic [7:0] ADR [5] =
    '{ADDR_THREE, ADDR_FOUR, ADDR_FIVE, ADDR_SIX, 8'h1C};

  ipl_prio_regs ipl_prio_regs_i (.*);
  ipl_host_model ipl_host_model_i (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_src();
    logic [NUM_SRC-1:0] en;
    logic [2*NUM_SRC-1:0] lv;
    logic [1:0] f;
    @(negedge sys_clk);
    for (int s = 0; s < NUM_SRC; s++) begin
      f = 2'(mreg[SRC_SLOT[s]] >> SRC_LSB[s]);
      en[s] = (f != 2'h0);
      lv[2*s +: 2] = (f == 2'h0) ? 2'h0 : f - 2'h1;
    end
    `CHK("enable", en, source_enable)
    `CHK("level_a", lv[23:0], source_level[23:0])
    `CHK("level_b", lv[31:24], source_level[31:24])
    `CHK("level_c", lv[39:32], source_level[39:32])
  endtask

  task automatic put(int i, logic [31:0] d, logic [3:0] s, int dly);
    logic [1:0] r;
    ipl_host_model_i.wr(ADR[i], d, s, dly, r);
    `CHK("bresp", (i < NUM_REG) ? RESP_OKAY : RESP_SLVERR, r)
    if (i < NUM_REG && s[0]) mreg[i][7:0] = d[7:0] & MSK[i][7:0];
    if (i < NUM_REG && s[1]) mreg[i][15:8] = d[15:8] & MSK[i][15:8];
    chk_src();
  endtask

  task automatic get(int i, int dly);
    logic [1:0] r;
    logic [31:0] d;
    ipl_host_model_i.rd(ADR[i], dly, d, r);
    `CHK("rresp", (i < NUM_REG) ? RESP_OKAY : RESP_SLVERR, r)
    `CHK("rdata", (i < NUM_REG) ? {16'h0, mreg[i]} : 32'h0, d)
  endtask

  initial begin
    num_errors = 0;
    compares = 0;
    rng = 32'h1A756F27;
    arst_n = 1'b0;
    foreach (mreg[k]) mreg[k] = PRIO_RESET;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk_src();
    for (int i = 0; i < 5; i++) get(i, 0);
    // Each code of each field, with slower answers for higher codes
    for (int s = 0; s < NUM_SRC; s++) begin
      for (int c = 0; c < 4; c++) put(SRC_SLOT[s], 32'(c) << SRC_LSB[s], 4'hF, c);
    end
    repeat (150) begin
      put(int'(nxt() % 5), nxt(), 4'(nxt()), int'(nxt() % 4));
      get(int'(nxt() % 5), int'(nxt() % 4));
    end
    // Reset in mid-run must clear every field again
    @(posedge sys_clk);
    arst_n <= 1'b0;
    foreach (mreg[k]) mreg[k] = PRIO_RESET;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk_src();
    get(1, 0);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule
